// *** sdram_ctrl_config_regs.sv ***
// SDRAM controller config registers
// and the engines they steer:
// clock, refresh, setup, arbiter, remap.
// Assumes a Wishbone master on the core
// clock.
//
// Our own choice: the Wishbone slave port.
`include "sdram_cfg_regs.svh"
`timescale 1ns/10ps
module sdram_ctrl_config_regs #(
    parameter logic [31:0] CONFIG_BASE = 32'h4000_0000 // Arbitrary
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pad controls
    output mem_cfg_pkg::pad_drive_t pad_drive,
    // Memory clock pins, two half-cycle samples each
    output logic [3:0][1:0] memory_clock_pin,
    output logic [1:0] feedback_clock_pin,
    output logic rd_latch_r,
    // Refresh
    output logic [1:0] refresh_bank_r,
    // Command issue
    input wire logic cmd_req,
    output logic addr_drive_r,
    output logic cs_n_r,
    // Arbitration
    input wire mem_cfg_pkg::arb_req_t arb_req,
    output mem_cfg_pkg::arb_req_t arb_grant_r,
    // SMM remap
    input wire logic [31:0] req_addr,
    output logic [31:0] phys_addr_r,
    output logic smm_hit_r,
    // Device programming
    output logic sdram_prog_r,
    output logic [2:0] cas_latency_r
);
    logic [31:0] mem_ctrl_one;
    logic [31:0] mem_ctrl_two;
    logic [31:0] bank_config;
    logic [31:0] sync_timing_one;
    logic [31:0] graphics_base_address;
    logic [31:0] dirty_ram_address;
    logic [31:0] dirty_ram_access;
    logic ack_r;
    logic wr_go;
    logic launch_prev_r;
    logic prog_prev_r;
    logic test_prev_r;
    logic launch_pulse_r;
    logic [1:0] clk_phase;
    logic clk_rise;
    logic rise_d_r;
    logic [8:0] rfsh_cnt_r;
    logic rfsh_pend_r;
    logic rfsh_tick;
    logic [2:0] gap_r;
    mem_cfg_pkg::rfsh_state_t rf_state_r;
    logic cs_pend_r;
    logic [1:0] rr_last_r;
    logic [31:0] smm_ofs;
    logic [4:0] mask_n;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    function automatic logic hit(input logic [15:0] ofs);
        hit = wr_go && wb_adr_i == ofs;
    endfunction : hit

    // Stagger code to memory clock count
    function automatic logic [2:0] gap_of(input logic [1:0] code);
        case (code)
            2'b00: gap_of = 3'h0;
            2'b01: gap_of = 3'h1;
            2'b10: gap_of = 3'h2;
            default: gap_of = 3'h4;
        endcase
    endfunction : gap_of

    // Ack one cycle after the request
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    assign wb_ack_o = ack_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_dat_o <= `RST_ZERO;
        end else if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
            case (wb_adr_i)
                `OFS_CTRL_ONE: wb_dat_o <= mem_ctrl_one;
                `OFS_CTRL_TWO: wb_dat_o <= mem_ctrl_two;
                `OFS_BANK_CFG: wb_dat_o <= bank_config;
                `OFS_SYNC_TIM: wb_dat_o <= sync_timing_one;
                `OFS_GFX_BASE: wb_dat_o <= graphics_base_address;
                `OFS_DIRTY_ADR: wb_dat_o <= dirty_ram_address;
                `OFS_DIRTY_ACC: wb_dat_o <= dirty_ram_access;
                default: wb_dat_o <= `RST_ZERO;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_ctrl_one <= `RST_CTRL_ONE;
            mem_ctrl_two <= `RST_CTRL_TWO;
            bank_config <= `RST_BANK_CFG;
            sync_timing_one <= `RST_SYNC_TIM;
            graphics_base_address <= `RST_ZERO;
            dirty_ram_address <= `RST_ZERO;
            dirty_ram_access <= `RST_ZERO;
        end else begin
            if (hit(`OFS_CTRL_ONE)) begin
                mem_ctrl_one <= merge(mem_ctrl_one, wb_dat_i, wb_sel_i);
            end
            if (hit(`OFS_CTRL_TWO)) begin
                mem_ctrl_two <= merge(mem_ctrl_two, wb_dat_i, wb_sel_i);
            end
            if (hit(`OFS_BANK_CFG)) begin
                bank_config <= merge(bank_config, wb_dat_i, wb_sel_i);
            end
            if (hit(`OFS_SYNC_TIM)) begin
                sync_timing_one <= merge(sync_timing_one, wb_dat_i,
                                         wb_sel_i);
            end
            if (hit(`OFS_GFX_BASE)) begin
                graphics_base_address <= merge(graphics_base_address,
                                               wb_dat_i, wb_sel_i);
            end
            if (hit(`OFS_DIRTY_ADR)) begin
                dirty_ram_address <= merge(dirty_ram_address, wb_dat_i,
                                           wb_sel_i);
            end
            if (hit(`OFS_DIRTY_ACC)) begin
                dirty_ram_access <= merge(dirty_ram_access, wb_dat_i,
                                          wb_sel_i);
            end
        end
    end

    // Pad drives straight from register flops
    assign pad_drive.data_pin_drive = mem_ctrl_one[`F_DATA_DRV];
    assign pad_drive.addr_pin_drive = mem_ctrl_one[`F_ADDR_DRV];
    assign pad_drive.cmd_pin_drive = mem_ctrl_one[`F_CMD_DRV];
    assign pad_drive.clock_pad_drive = mem_ctrl_two[`F_CLK_DRV];

    // Edge detection on the trigger bits
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            launch_prev_r <= 1'b0;
            prog_prev_r <= 1'b0;
            test_prev_r <= 1'b0;
            launch_pulse_r <= 1'b0;
            sdram_prog_r <= 1'b0;
        end else begin
            launch_prev_r <= mem_ctrl_one[`B_LAUNCH];
            prog_prev_r <= mem_ctrl_one[`B_SDRAM_PROG];
            test_prev_r <= mem_ctrl_one[`B_RFSH_TEST];
            launch_pulse_r <= mem_ctrl_one[`B_LAUNCH]
                && !launch_prev_r;
            sdram_prog_r <= mem_ctrl_one[`B_SDRAM_PROG]
                && !prog_prev_r;
        end
    end

    // Latency held for the programming sequence
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cas_latency_r <= 3'h2;
        end else if (mem_ctrl_one[`B_SDRAM_PROG] && !prog_prev_r) begin
            cas_latency_r <= sync_timing_one[`F_CAS_LAT];
        end
    end

    sdram_clk_gen u_clk (
        .sys_clk(sys_clk),
        .rst(rst),
        .launch(launch_pulse_r),
        .ratio(mem_ctrl_one[`F_RATIO]),
        .shift(mem_ctrl_two[`F_SHIFT]),
        .phase_r(clk_phase),
        .rise_r(clk_rise),
        .running_r()
    );

    // Masks are re-registered so pins come from flops
    assign mask_n = mem_ctrl_two[`F_CLK_MASK];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            feedback_clock_pin <= 2'b00;
        end else begin
            feedback_clock_pin <= mask_n[4] ? 2'b00 : clk_phase;
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_clk_pin
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                memory_clock_pin[g] <= 2'b00;
            end else begin
                memory_clock_pin[g] <= mask_n[g] ? 2'b00 : clk_phase;
            end
        end
    end

    // Read data strobe after memory clock rise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rise_d_r <= 1'b0;
            rd_latch_r <= 1'b0;
        end else begin
            rise_d_r <= clk_rise;
            rd_latch_r <= mem_ctrl_two[`B_RD_PHASE]
                ? rise_d_r : clk_rise;
        end
    end

    // Refresh interval counter
    assign rfsh_tick = mem_ctrl_one[`F_RFSH_INT] != 9'h000
        && rfsh_cnt_r >= mem_ctrl_one[`F_RFSH_INT] - 9'h001;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rfsh_cnt_r <= 9'h000;
        end else if (mem_ctrl_one[`F_RFSH_INT] == 9'h000) begin
            rfsh_cnt_r <= 9'h000;
        end else if (rfsh_tick) begin
            rfsh_cnt_r <= 9'h000;
        end else begin
            rfsh_cnt_r <= rfsh_cnt_r + 9'h001;
        end
    end

    // Pending request; a new request wins over the clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rfsh_pend_r <= 1'b0;
        end else if (rfsh_tick || (mem_ctrl_one[`B_RFSH_TEST]
                     && !test_prev_r)) begin
            rfsh_pend_r <= 1'b1;
        end else if (rf_state_r == mem_cfg_pkg::RF_IDLE) begin
            rfsh_pend_r <= 1'b0;
        end
    end

    // Bank refresh sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rf_state_r <= mem_cfg_pkg::RF_IDLE;
            refresh_bank_r <= 2'b00;
            gap_r <= 3'h0;
        end else begin
            refresh_bank_r <= 2'b00;
            case (rf_state_r)
                mem_cfg_pkg::RF_IDLE: begin
                    if (rfsh_pend_r) begin
                        gap_r <= gap_of(mem_ctrl_one[`F_STAGGER]);
                        if (mem_ctrl_one[`F_STAGGER] == 2'b00) begin
                            refresh_bank_r <= 2'b11;
                        end else begin
                            refresh_bank_r <= 2'b01;
                            rf_state_r <= mem_cfg_pkg::RF_GAP;
                        end
                    end
                end
                mem_cfg_pkg::RF_GAP: begin
                    if (clk_rise) begin
                        gap_r <= gap_r - 3'h1;
                        if (gap_r == 3'h1) begin
                            rf_state_r <= mem_cfg_pkg::RF_SECOND;
                        end
                    end
                end
                mem_cfg_pkg::RF_SECOND: begin
                    refresh_bank_r <= 2'b10;
                    rf_state_r <= mem_cfg_pkg::RF_IDLE;
                end
                default: begin
                    rf_state_r <= mem_cfg_pkg::RF_IDLE;
                end
            endcase
        end
    end

    // Address and chip select for one command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_drive_r <= 1'b0;
            cs_n_r <= 1'b1;
            cs_pend_r <= 1'b0;
        end else if (cmd_req) begin
            addr_drive_r <= 1'b1;
            cs_pend_r <= mem_ctrl_one[`B_EARLY_ADR];
            cs_n_r <= mem_ctrl_one[`B_EARLY_ADR];
        end else if (cs_pend_r) begin
            cs_pend_r <= 1'b0;
            cs_n_r <= 1'b0;
        end else begin
            addr_drive_r <= 1'b0;
            cs_n_r <= 1'b1;
        end
    end

    // Arbiter; urgent display requests never wait
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arb_grant_r <= '0;
            rr_last_r <= 2'd0;
        end else begin
            arb_grant_r <= '0;
            if (arb_req.hp_disp) begin
                arb_grant_r.hp_disp <= 1'b1;
            end else if (!mem_ctrl_one[`B_ROUND_ROBIN]) begin
                if (arb_req.cpu) begin
                    arb_grant_r.cpu <= 1'b1;
                end else if (arb_req.gfx) begin
                    arb_grant_r.gfx <= 1'b1;
                end else if (arb_req.lp_disp) begin
                    arb_grant_r.lp_disp <= 1'b1;
                end
            end else begin
                // Search starts just past the last winner
                case (rr_last_r)
                    2'd0: begin
                        if (arb_req.gfx) begin
                            arb_grant_r.gfx <= 1'b1;
                            rr_last_r <= 2'd1;
                        end else if (arb_req.lp_disp) begin
                            arb_grant_r.lp_disp <= 1'b1;
                            rr_last_r <= 2'd2;
                        end else if (arb_req.cpu) begin
                            arb_grant_r.cpu <= 1'b1;
                        end
                    end
                    2'd1: begin
                        if (arb_req.lp_disp) begin
                            arb_grant_r.lp_disp <= 1'b1;
                            rr_last_r <= 2'd2;
                        end else if (arb_req.cpu) begin
                            arb_grant_r.cpu <= 1'b1;
                            rr_last_r <= 2'd0;
                        end else if (arb_req.gfx) begin
                            arb_grant_r.gfx <= 1'b1;
                        end
                    end
                    default: begin
                        if (arb_req.cpu) begin
                            arb_grant_r.cpu <= 1'b1;
                            rr_last_r <= 2'd0;
                        end else if (arb_req.gfx) begin
                            arb_grant_r.gfx <= 1'b1;
                            rr_last_r <= 2'd1;
                        end else if (arb_req.lp_disp) begin
                            arb_grant_r.lp_disp <= 1'b1;
                            rr_last_r <= 2'd2;
                        end
                    end
                endcase
            end
        end
    end

    // SMM window remap
    assign smm_ofs = req_addr - (CONFIG_BASE + `SMM_SRC_OFS);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phys_addr_r <= `RST_ZERO;
            smm_hit_r <= 1'b0;
        end else if (mem_ctrl_one[`B_SMM_REMAP] && smm_ofs < `SMM_SIZE) begin
            phys_addr_r <= `SMM_DST + smm_ofs;
            smm_hit_r <= 1'b1;
        end else begin
            phys_addr_r <= req_addr;
            smm_hit_r <= 1'b0;
        end
    end

endmodule : sdram_ctrl_config_regs

// *** sdram_cfg_regs.svh ***
// Offsets, fields and reset values of the SDRAM config block.
// Assumes byte addresses on a 32-bit Wishbone port.
//
// Overview of operation
// - 2-bit drive fields for data, address and command pins.
// - Memory clock is core clock divided by 2 to 5.
// - New ratio applies only on a launch bit rise.
// - Refresh interval in core clocks; zero disables.
// - Bank refreshes spaced 0, 1, 2 or 4 memory clocks.
// - Early setup drives address a clock before select.
// - Refresh test bit raises a refresh request.
// - Round robin or cpu first; urgent display always wins.
// - SMM window maps onto A0000 to BFFFF.
// - Program bit rise programs the SDRAMs.
// - 2-bit drive field for memory clock outputs.
// - Clock shift in half core clocks, on launch.
// - Read data latched one or two clocks after rise.
`ifndef SDRAM_CFG_REGS_SVH
`define SDRAM_CFG_REGS_SVH

`define OFS_CTRL_ONE 16'h8400
`define OFS_CTRL_TWO 16'h8404
`define OFS_BANK_CFG 16'h8408
`define OFS_SYNC_TIM 16'h840C
`define OFS_GFX_BASE 16'h8414
`define OFS_DIRTY_ADR 16'h8418
`define OFS_DIRTY_ACC 16'h841C

`define RST_CTRL_ONE 32'h248C_0040
`define RST_CTRL_TWO 32'h0000_0801
`define RST_BANK_CFG 32'h4110_4110
`define RST_SYNC_TIM 32'h2A73_3225
`define RST_ZERO 32'h0000_0000

`define F_DATA_DRV 31:30
`define F_ADDR_DRV 28:27
`define F_CMD_DRV 25:24
`define F_RATIO 20:18
`define B_LAUNCH 17
`define F_RFSH_INT 16:8
`define F_STAGGER 7:6
`define B_EARLY_ADR 5
`define B_RFSH_TEST 4
`define B_ROUND_ROBIN 3
`define B_SMM_REMAP 2
`define B_SDRAM_PROG 0
`define F_CLK_DRV 13:12
`define F_CLK_MASK 10:6
`define F_SHIFT 5:3
`define B_RD_PHASE 1
`define F_CAS_LAT 30:28

`define SMM_SRC_OFS 32'h0040_0000
`define SMM_DST 32'h000A_0000
`define SMM_SIZE 32'h0002_0000
`define RATIO_RSVD 3'h0
`define SHIFT_RSVD 3'h7

`endif

// *** mem_cfg_pkg.sv ***
// Types shared by the SDRAM configuration block, its port checker and the bench.
// Assumes the constants header for all numbers.
package mem_cfg_pkg;

    typedef struct packed {
        logic [1:0] data_pin_drive;
        logic [1:0] addr_pin_drive;
        logic [1:0] cmd_pin_drive;
        logic [1:0] clock_pad_drive;
    } pad_drive_t;

    typedef struct packed {
        logic hp_disp;
        logic cpu;
        logic gfx;
        logic lp_disp;
    } arb_req_t;

    typedef enum logic [2:0] {
        RF_IDLE = 3'b001,
        RF_GAP = 3'b010,
        RF_SECOND = 3'b100
    } rfsh_state_t;

endpackage : mem_cfg_pkg

// *** sdram_clk_gen.sv ***
// Memory clock maker in half-cycle steps.
// Assumes launch is a one-cycle pulse.
`timescale 1ns/10ps
module sdram_clk_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Settings
    input wire logic launch,
    input wire logic [2:0] ratio,
    input wire logic [2:0] shift,
    // Clock out: bit 1 first half of core cycle, bit 0 second half
    output logic [1:0] phase_r,
    output logic rise_r,
    output logic running_r
);
    logic [3:0] period_r;
    logic [3:0] pos_r;
    logic [3:0] q1;
    logic [3:0] new_p;

    function automatic logic [3:0] wrap(input logic [4:0] v,
                                        input logic [3:0] p);
        logic [4:0] t;
        t = (v >= {1'b0, p}) ? v - {1'b0, p} : v;
        wrap = (t >= {1'b0, p}) ? 4'(t - {1'b0, p}) : t[3:0];
    endfunction : wrap

    // Odd periods keep the extra half cycle high
    function automatic logic level(input logic [3:0] q,
                                   input logic [3:0] p);
        logic [4:0] hi;
        hi = ({1'b0, p} + 5'h01) >> 1;
        level = {1'b0, q} < hi;
    endfunction : level

    assign new_p = 4'(ratio) + 4'h3;
    assign q1 = wrap({1'b0, pos_r} + 5'h01, period_r);

    // Reserved codes leave the old setting running
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            period_r <= 4'h6;
            pos_r <= 4'h0;
            running_r <= 1'b0;
        end else if (launch && ratio != `RATIO_RSVD
                     && shift != `SHIFT_RSVD) begin
            period_r <= new_p;
            pos_r <= wrap({new_p, 1'b0} - {2'b00, shift}, new_p);
            running_r <= 1'b1;
        end else begin
            pos_r <= wrap({1'b0, pos_r} + 5'h02, period_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_r <= 2'b00;
            rise_r <= 1'b0;
        end else if (running_r) begin
            phase_r <= {level(pos_r, period_r), level(q1, period_r)};
            rise_r <= (pos_r == 4'h0) || (q1 == 4'h0);
        end else begin
            phase_r <= 2'b00;
            rise_r <= 1'b0;
        end
    end

endmodule : sdram_clk_gen

// *** sdram_cfg_monitor.sv ***
// Port checker for the SDRAM config block.
// Assumes binding; sees ports only.
`include "sdram_cfg_regs.svh"
`timescale 1ns/10ps
module sdram_cfg_monitor #(
    parameter logic [31:0] CONFIG_BASE = 32'h4000_0000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Memory side
    input wire logic [3:0][1:0] memory_clock_pin,
    input wire logic addr_drive_r,
    input wire logic cs_n_r,
    input wire logic sdram_prog_r,
    // Arbitration and remap
    input wire mem_cfg_pkg::arb_req_t arb_req,
    input wire mem_cfg_pkg::arb_req_t arb_grant_r,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] phys_addr_r,
    input wire logic smm_hit_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [31:0] win_ofs;
    assign win_ofs = req_addr - CONFIG_BASE - `SMM_SRC_OFS;
    sequence s_cs_pulse;
        !cs_n_r ##1 cs_n_r;
    endsequence
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_rst;
        $fell(rst) |-> memory_clock_pin == '0 && cs_n_r && !sdram_prog_r;
    endproperty
    property p_cs;
        $fell(cs_n_r) |-> addr_drive_r ##0 s_cs_pulse;
    endproperty
    property p_hp;
        arb_req.hp_disp |=> arb_grant_r == 4'b1000;
    endproperty
    property p_onehot;
        $onehot0(arb_grant_r);
    endproperty
    property p_smm;
        smm_hit_r |-> $past(win_ofs) < `SMM_SIZE &&
            phys_addr_r == `SMM_DST + $past(win_ofs);
    endproperty
    property p_prog;
        sdram_prog_r |=> !sdram_prog_r [*3];
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    a_ack_one: assert property (p_ack_one) else $error("long ack");
    a_rst: assert property (p_rst) else $error("bad reset");
    a_cs: assert property (p_cs) else $error("bad select");
    a_hp: assert property (p_hp) else $error("urgent lost");
    a_onehot: assert property (p_onehot) else $error("grant");
    a_smm: assert property (p_smm) else $error("bad remap");
    a_prog: assert property (p_prog) else $error("prog pulse");
endmodule : sdram_cfg_monitor

// *** sdram_dev_model.sv ***
// SDRAM side: counts clock rises, keeps mode.
// Assumes pins are half-cycle sample pairs.
`timescale 1ns/10ps
module sdram_dev_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Memory pins
    input wire logic [1:0] clk_pin,
    input wire logic prog,
    input wire logic [2:0] cas,
    // Observations
    output int rises,
    output logic [2:0] mode_cas
);
    logic last_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rises <= 0;
            last_r <= 1'b0;
        end else begin
            rises <= rises + int'(!last_r && clk_pin[1])
                + int'(!clk_pin[1] && clk_pin[0]);
            last_r <= clk_pin[0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (prog) begin
            mode_cas <= cas;
        end
    end
endmodule : sdram_dev_model

// *** tb.sv ***
// Self-checking bench for the SDRAM config block.
// Assumes all design files are compiled.
`include "sdram_cfg_regs.svh"
`timescale 1ns/10ps
module tb;
    localparam logic [31:0] BASE = 32'h4000_0000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, cmd_req = 1'b0;
    logic [15:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, req_addr = '0, wb_dat_o, phys_addr_r, rd;
    logic [31:0] c1 = `RST_CTRL_ONE;
    logic wb_ack_o, rd_latch_r, addr_drive_r, cs_n_r, smm_hit_r, sdram_prog_r;
    logic [2:0] cas_latency_r, mode_cas;
    logic [1:0] feedback_clock_pin, refresh_bank_r;
    logic [3:0][1:0] memory_clock_pin;
    mem_cfg_pkg::pad_drive_t pad_drive;
    mem_cfg_pkg::arb_req_t arb_req = '0, arb_grant_r;
    int err_total = 0, checks = 0, rises, b0 = 0, b1 = 0, both = 0;
    sdram_ctrl_config_regs #(.CONFIG_BASE(BASE)) dut (.sys_clk, .rst,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .pad_drive, .memory_clock_pin,
        .feedback_clock_pin, .rd_latch_r, .refresh_bank_r, .cmd_req,
        .addr_drive_r, .cs_n_r, .arb_req, .arb_grant_r, .req_addr,
        .phys_addr_r, .smm_hit_r, .sdram_prog_r, .cas_latency_r);
    sdram_dev_model model (.sys_clk, .rst, .clk_pin(memory_clock_pin[0]),
        .prog(sdram_prog_r), .cas(cas_latency_r), .rises, .mode_cas);
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        b0 += refresh_bank_r[0];
        b1 += refresh_bank_r[1];
        both += &refresh_bank_r;
    end
    task automatic stop_test;
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [15:0] a,
        input logic [31:0] d, input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
        do @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && ++n < 20);
        if (n >= 20) err_total++;
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task automatic w1(input logic [31:0] v);
        c1 = v & ~32'h0020_0000;
        wb(1'b1, `OFS_CTRL_ONE, c1);
    endtask : w1
    task automatic cnt(input int exp);
        int r0;
        repeat (10) @(posedge sys_clk);
        r0 = rises;
        repeat (40) @(posedge sys_clk);
        chk(rises - r0, exp);
    endtask : cnt
    task automatic t_regs;
        logic [15:0] ofs [6] = '{`OFS_CTRL_ONE, `OFS_CTRL_TWO, `OFS_BANK_CFG,
            `OFS_SYNC_TIM, `OFS_GFX_BASE, `OFS_DIRTY_ADR};
        logic [31:0] rv [6] = '{`RST_CTRL_ONE, `RST_CTRL_TWO, `RST_BANK_CFG,
            `RST_SYNC_TIM, `RST_ZERO, `RST_ZERO};
        foreach (ofs[i]) begin
            wb(1'b0, ofs[i], '0);
            chk(rd, rv[i]);
        end
        for (int i = 2; i < 6; i++) begin
            wb(1'b1, ofs[i], 32'hA5C3_3C5A, 4'b0101);
            wb(1'b0, ofs[i], '0);
            chk(rd, (rv[i] & 32'hFF00_FF00) | 32'h00C3_005A);
        end
        wb(1'b1, 16'h8410, 32'hFFFF_FFFF);
        wb(1'b0, 16'h8410, '0);
        chk(rd, 32'h0000_0000);
        w1(c1 | 32'hCA00_0000);
        wb(1'b1, `OFS_CTRL_TWO, 32'h0000_2801);
        chk(32'(pad_drive), 32'h0000_00DA);
    endtask : t_regs
    task automatic t_clock;
        logic [2:0] rt [4] = '{3'h1, 3'h2, 3'h5, 3'h7};
        int ex [4] = '{20, 16, 10, 8};
        int prev;
        prev = 0;
        foreach (rt[i]) begin
            w1((c1 & ~32'h003E_0000) | {11'h0, rt[i], 18'h0});
            cnt(prev);
            w1(c1 | 32'h0002_0000);
            cnt(ex[i]);
            prev = ex[i];
        end
        wb(1'b1, `OFS_CTRL_TWO, 32'h0000_2841);
        cnt(0);
        wb(1'b1, `OFS_CTRL_TWO, 32'h0000_2801);
    endtask : t_clock
    task automatic t_rfsh;
        int a0, a1, ab;
        w1(c1 & ~32'h0000_00D0);
        {a0, ab} = {b0, both};
        w1(c1 | 32'h0000_0010);
        repeat (20) @(posedge sys_clk);
        chk(b0 - a0, 1);
        chk(both - ab, 1);
        w1(c1 & ~32'h0000_0010);
        {a1, ab} = {b1, both};
        w1(c1 | 32'h0000_0050);
        repeat (40) @(posedge sys_clk);
        chk(b1 - a1, 1);
        chk(both - ab, 0);
        for (int n = 20; n >= 0; n -= 20) begin
            w1((c1 & ~32'h0001_FFD0) | {15'h0, 9'(n), 8'h0});
            repeat (30) @(posedge sys_clk);
            a0 = b0;
            repeat (100) @(posedge sys_clk);
            chk(b0 - a0, n / 4);
        end
    endtask : t_rfsh
    task automatic lat(output int n);
        n = 0;
        @(posedge sys_clk);
        cmd_req <= 1'b1;
        @(posedge sys_clk);
        cmd_req <= 1'b0;
        while (cs_n_r !== 1'b0 && n < 9) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : lat
    task automatic t_misc;
        int np, ne;
        mem_cfg_pkg::arb_req_t g;
        lat(np);
        w1(c1 | 32'h0000_0020);
        lat(ne);
        chk(ne - np, 1);
        arb_req <= 4'b0110;
        repeat (3) @(posedge sys_clk);
        chk(arb_grant_r, 4'b0100);
        w1(c1 | 32'h0000_0008);
        g = arb_grant_r;
        @(posedge sys_clk);
        chk(g | arb_grant_r, 4'b0110);
        arb_req <= 4'b1110;
        repeat (3) @(posedge sys_clk);
        chk(arb_grant_r, 4'b1000);
        req_addr <= BASE + 32'h0040_1234;
        repeat (2) @(posedge sys_clk);
        chk(smm_hit_r, 1'b0);
        w1(c1 | 32'h0000_0004);
        @(posedge sys_clk);
        chk(smm_hit_r, 1'b1);
        chk(phys_addr_r, 32'h000A_1234);
        wb(1'b1, `OFS_SYNC_TIM, 32'h5A73_3225);
        w1(c1 | 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        chk(cas_latency_r, 3'h5);
        chk(mode_cas, 3'h5);
    endtask : t_misc
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_clock();
        t_rfsh();
        t_misc();
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        wb(1'b0, `OFS_CTRL_ONE, '0);
        chk(rd, `RST_CTRL_ONE);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        stop_test();
    end
endmodule : tb
bind sdram_ctrl_config_regs sdram_cfg_monitor #(.CONFIG_BASE(CONFIG_BASE))
    mon (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .memory_clock_pin,
    .addr_drive_r, .cs_n_r, .sdram_prog_r, .arb_req, .arb_grant_r,
    .req_addr, .phys_addr_r, .smm_hit_r);
